// ---- logic/sctg_guard.sv ----
// Command spacing guard that drives the DRAM command pins.
`timescale 1ns/1ns
module sctg_guard (
  input wire logic CLK_I,
  input wire logic RST_N_I,
  input wire logic CMD_VALID_I,
  input wire sctg_pkg::sctg_cmd_t CMD_CODE_I,
  input wire logic CMD_BG_I,
  input wire logic [1:0] CMD_BA_I,
  input wire logic [sctg_pkg::ADDR_W-1:0] CMD_ADDR_I,
  output logic CMD_READY_O,
  input wire logic CRC_EN_I,
  input wire logic DM_EN_I,
  input wire logic CAL_EN_I,
  input wire logic FAST_GRADE_I,
  input wire logic LONG_PREAMBLE_I,
  input wire logic [sctg_pkg::LAT_W-1:0] ADDITIVE_LATENCY_I,
  input wire logic [sctg_pkg::LAT_W-1:0] PARITY_LATENCY_I,
  input wire logic [sctg_pkg::LAT_W-1:0] WR_DATA_LAT_I,
  output logic DDR_CS_N_O,
  output logic DDR_ACT_N_O,
  output logic DDR_RAS_N_O,
  output logic DDR_CAS_N_O,
  output logic DDR_WE_N_O,
  output logic DDR_BG_O,
  output logic [1:0] DDR_BA_O,
  output logic [sctg_pkg::ADDR_W-1:0] DDR_ADDR_O,
  output logic [1:0] RD_PREAMBLE_CYC_O,
  output logic RD_ISSUED_O
);
  import sctg_pkg::*;

  // ---------------------------------------------------------------------
  // State
  // ---------------------------------------------------------------------
  typedef struct packed {
    sctg_state_t state;
    logic [TW-1:0] cal_cnt;
    sctg_cmd_t h_cmd;
    logic h_bg;
    logic [1:0] h_ba;
    logic [ADDR_W-1:0] h_addr;
    logic wr_bg;
    logic cs_n;
    logic [3:0] pins;
    logic bg;
    logic [1:0] ba;
    logic [ADDR_W-1:0] addr;
    logic [1:0] pre_cyc;
    logic rd_pulse;
  } sctg_st_t;

  localparam sctg_st_t ST_RESET = '{
    state: SCTG_IDLE, cal_cnt: T_ZERO, h_cmd: SCTG_NOP, h_bg: 1'b0,
    h_ba: 2'h0, h_addr: 14'h0000, wr_bg: 1'b0, cs_n: 1'b1,
    pins: PIN_IDLE, bg: 1'b0, ba: 2'h0, addr: 14'h0000,
    pre_cyc: PRE_SHORT, rd_pulse: 1'b0};

  sctg_st_t st_r;
  sctg_st_t st_nxt;

  logic [N_TMR-1:0] t_busy;
  logic [N_TMR-1:0] t_load;
  logic [TW-1:0] t_val [N_TMR];

  logic crc_dm;
  logic [TW-1:0] tcal;
  logic [TW-1:0] xtra;
  logic [TW-1:0] wlat;
  logic gate_ok;
  logic accept;
  logic fire;
  sctg_cmd_t f_cmd;
  logic f_bg;
  logic [1:0] f_ba;
  logic [ADDR_W-1:0] f_addr;

  // ---------------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------------
  // A timer loaded with n-1 lets the next command go n cycles later.
  function automatic logic [TW-1:0] gap(input logic [TW-1:0] n);
    return (n > T_ZERO) ? (n - T_ONE) : T_ZERO;
  endfunction

  function automatic logic [3:0] pin_of(input sctg_cmd_t c);
    case (c)
      SCTG_ACT: pin_of = PIN_ACT;
      SCTG_RD, SCTG_MPR_RD: pin_of = PIN_RD;
      SCTG_WR, SCTG_WRA, SCTG_MPR_WR: pin_of = PIN_WR;
      SCTG_PRE: pin_of = PIN_PRE;
      SCTG_MRS: pin_of = PIN_MRS;
      SCTG_REF: pin_of = PIN_REF;
      default: pin_of = PIN_IDLE;
    endcase
  endfunction

  function automatic logic is_read(input sctg_cmd_t c);
    return (c == SCTG_RD) || (c == SCTG_MPR_RD);
  endfunction

  function automatic logic is_write(input sctg_cmd_t c);
    return (c == SCTG_WR) || (c == SCTG_WRA);
  endfunction

  // ---------------------------------------------------------------------
  // Spacing figures for the present mode
  // ---------------------------------------------------------------------
  assign crc_dm = CRC_EN_I && DM_EN_I;
  assign xtra = crc_dm ? C_CRCDM : T_ZERO;
  assign tcal = FAST_GRADE_I ? C_CAL_FAST : C_CAL_SLOW;
  // Write timings count from the end of the write burst, not the command.
  assign wlat = TW'(WR_DATA_LAT_I);

  // ---------------------------------------------------------------------
  // Gate: may the offered command go now
  // ---------------------------------------------------------------------
  always_comb begin
    logic blk;
    blk = t_busy[TI_MPR];
    case (CMD_CODE_I)
      SCTG_MRS: begin
        blk = blk || t_busy[TI_MRD];
      end
      SCTG_RD, SCTG_MPR_RD: begin
        blk = blk || t_busy[TI_MOD];
        if (CMD_BG_I == st_r.wr_bg) begin
          blk = blk || t_busy[TI_WTRL];
        end else begin
          blk = blk || t_busy[TI_WTRS];
        end
      end
      SCTG_PRE: begin
        blk = blk || t_busy[TI_MOD] ||
              t_busy[TI_PRE + int'({CMD_BG_I, CMD_BA_I})];
      end
      SCTG_ACT: begin
        blk = blk || t_busy[TI_MOD] ||
              t_busy[TI_DAL + int'({CMD_BG_I, CMD_BA_I})];
      end
      default: begin
        blk = blk || t_busy[TI_MOD];
      end
    endcase
    gate_ok = !blk;
  end

  assign CMD_READY_O = (st_r.state == SCTG_IDLE) && gate_ok;
  assign accept = CMD_VALID_I && CMD_READY_O;

  // ---------------------------------------------------------------------
  // Sequencer
  // ---------------------------------------------------------------------
  always_comb begin
    st_nxt = st_r;
    st_nxt.cs_n = 1'b1;
    st_nxt.pins = PIN_IDLE;
    st_nxt.rd_pulse = 1'b0;
    st_nxt.pre_cyc = LONG_PREAMBLE_I ? PRE_LONG : PRE_SHORT;
    fire = 1'b0;
    f_cmd = CMD_CODE_I;
    f_bg = CMD_BG_I;
    f_ba = CMD_BA_I;
    f_addr = CMD_ADDR_I;
    case (st_r.state)
      SCTG_IDLE: begin
        if (accept) begin
          if (CAL_EN_I) begin
            // Chip select goes out alone; the command follows tcal later.
            st_nxt.cs_n = 1'b0;
            st_nxt.state = SCTG_LEAD;
            st_nxt.cal_cnt = gap(tcal);
            st_nxt.h_cmd = CMD_CODE_I;
            st_nxt.h_bg = CMD_BG_I;
            st_nxt.h_ba = CMD_BA_I;
            st_nxt.h_addr = CMD_ADDR_I;
          end else begin
            fire = 1'b1;
          end
        end
      end
      SCTG_LEAD: begin
        f_cmd = st_r.h_cmd;
        f_bg = st_r.h_bg;
        f_ba = st_r.h_ba;
        f_addr = st_r.h_addr;
        if (st_r.cal_cnt == T_ZERO) begin
          fire = 1'b1;
          st_nxt.state = SCTG_IDLE;
        end else begin
          st_nxt.cal_cnt = st_r.cal_cnt - T_ONE;
        end
      end
      default: begin
        st_nxt.state = SCTG_IDLE;
      end
    endcase
    if (fire) begin
      // In latency mode the command pins carry no chip select.
      st_nxt.cs_n = CAL_EN_I;
      st_nxt.pins = pin_of(f_cmd);
      st_nxt.bg = f_bg;
      st_nxt.ba = f_ba;
      st_nxt.addr = f_addr;
      if (f_cmd == SCTG_WRA) begin
        st_nxt.addr[AP_BIT] = 1'b1;
      end else if (f_cmd == SCTG_WR) begin
        st_nxt.addr[AP_BIT] = 1'b0;
      end
      if (is_write(f_cmd)) begin
        st_nxt.wr_bg = f_bg;
      end
      st_nxt.rd_pulse = is_read(f_cmd);
    end
  end

  // ---------------------------------------------------------------------
  // Timer loads on issued MRS, MPR and write commands
  // ---------------------------------------------------------------------
  always_comb begin
    logic [TW-1:0] cal_add;
    int bk;
    cal_add = CAL_EN_I ? tcal : T_ZERO;
    bk = int'({f_bg, f_ba});
    t_load = '0;
    for (int i = 0; i < N_TMR; i++) begin
      t_val[i] = T_ZERO;
    end
    if (fire) begin
      case (f_cmd)
        SCTG_MRS: begin
          t_load[TI_MRD] = 1'b1;
          t_val[TI_MRD] = CAL_EN_I ?
            gap(C_MOD + tcal) : gap(C_MRD);
          t_load[TI_MOD] = 1'b1;
          t_val[TI_MOD] = gap(C_MOD + cal_add);
        end
        SCTG_MPR_RD: begin
          t_load[TI_MPR] = 1'b1;
          t_val[TI_MPR] = gap(C_MPRR);
        end
        SCTG_MPR_WR: begin
          t_load[TI_MPR] = 1'b1;
          t_val[TI_MPR] = gap(C_MOD + TW'(ADDITIVE_LATENCY_I) +
                              TW'(PARITY_LATENCY_I));
        end
        SCTG_WR, SCTG_WRA: begin
          t_load[TI_WTRS] = 1'b1;
          t_val[TI_WTRS] = gap(wlat + C_WTR_S + xtra);
          t_load[TI_WTRL] = 1'b1;
          t_val[TI_WTRL] = gap(wlat + C_WTR_L + xtra);
          t_load[TI_PRE + bk] = 1'b1;
          t_val[TI_PRE + bk] = gap(wlat + C_WR + xtra);
          if (f_cmd == SCTG_WRA) begin
            t_load[TI_DAL + bk] = 1'b1;
            t_val[TI_DAL + bk] =
              gap(wlat + C_WR + xtra + C_RP);
          end
        end
        default: begin
          t_load = '0;
        end
      endcase
    end
  end

  // ---------------------------------------------------------------------
  // Timers
  // ---------------------------------------------------------------------
  sctg_tmr_if tif[N_TMR] ();

  for (genvar g = 0; g < N_TMR; g++) begin : g_tmr
    assign tif[g].load = t_load[g];
    assign tif[g].val = t_val[g];
    assign t_busy[g] = tif[g].busy;
    sctg_timer u_tmr (
      .clk_i(CLK_I),
      .rst_n_i(RST_N_I),
      .t(tif[g])
    );
  end

  // ---------------------------------------------------------------------
  // Registers and outputs
  // ---------------------------------------------------------------------
  always_ff @(posedge CLK_I) begin
    if (!RST_N_I) begin
      st_r <= ST_RESET;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign DDR_CS_N_O = st_r.cs_n;
  assign DDR_ACT_N_O = st_r.pins[3];
  assign DDR_RAS_N_O = st_r.pins[2];
  assign DDR_CAS_N_O = st_r.pins[1];
  assign DDR_WE_N_O = st_r.pins[0];
  assign DDR_BG_O = st_r.bg;
  assign DDR_BA_O = st_r.ba;
  assign DDR_ADDR_O = st_r.addr;
  assign RD_PREAMBLE_CYC_O = st_r.pre_cyc;
  assign RD_ISSUED_O = st_r.rd_pulse;
endmodule

// ---- logic/sctg_pkg.sv ----
// Package holding timing constants, encodings and types of the guard.
package sctg_pkg;

  // ---------------------------------------------------------------------
  // Clock and conversion
  // ---------------------------------------------------------------------
  localparam int CLK_PERIOD_PS = 100000;
  localparam int TW = 8;

  // Larger of a clock count and a time, the time rounded up to clocks.
  function automatic int cyc_of(input int nck, input int ps);
    int c;
    c = (ps + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    if (c < 1) begin
      c = 1;
    end
    return (nck > c) ? nck : c;
  endfunction

  // ---------------------------------------------------------------------
  // Times as printed
  // ---------------------------------------------------------------------
  localparam int T_WR_PS = 15000;
  localparam int T_CRCDM_NCK = 5;
  localparam int T_CRCDM_PS = 3750;
  localparam int T_WTR_S_NCK = 2;
  localparam int T_WTR_S_PS = 2500;
  localparam int T_WTR_L_NCK = 4;
  localparam int T_WTR_L_PS = 7500;
  localparam int T_MRD_NCK = 8;
  localparam int T_MOD_NCK = 24;
  localparam int T_MOD_PS = 15000;
  localparam int T_MPRR_NCK = 1;
  localparam int T_RP_PS = 15000;
  localparam int T_CAL_SLOW_NCK = 3;
  localparam int T_CAL_SLOW_PS = 3748;
  localparam int T_CAL_FAST_NCK = 5;

  // ---------------------------------------------------------------------
  // Derived cycle counts
  // ---------------------------------------------------------------------
  localparam logic [TW-1:0] C_WR = TW'(cyc_of(0, T_WR_PS));
  localparam logic [TW-1:0] C_CRCDM = TW'(cyc_of(T_CRCDM_NCK, T_CRCDM_PS));
  localparam logic [TW-1:0] C_WTR_S = TW'(cyc_of(T_WTR_S_NCK, T_WTR_S_PS));
  localparam logic [TW-1:0] C_WTR_L = TW'(cyc_of(T_WTR_L_NCK, T_WTR_L_PS));
  localparam logic [TW-1:0] C_MRD = TW'(cyc_of(T_MRD_NCK, 0));
  localparam logic [TW-1:0] C_MOD = TW'(cyc_of(T_MOD_NCK, T_MOD_PS));
  localparam logic [TW-1:0] C_MPRR = TW'(cyc_of(T_MPRR_NCK, 0));
  localparam logic [TW-1:0] C_RP = TW'(cyc_of(0, T_RP_PS));
  localparam logic [TW-1:0] C_CAL_SLOW =
    TW'(cyc_of(T_CAL_SLOW_NCK, T_CAL_SLOW_PS));
  localparam logic [TW-1:0] C_CAL_FAST = TW'(cyc_of(T_CAL_FAST_NCK, 0));
  localparam logic [TW-1:0] T_ZERO = 8'h00;
  localparam logic [TW-1:0] T_ONE = 8'h01;
  localparam logic [1:0] PRE_SHORT = 2'h1;
  localparam logic [1:0] PRE_LONG = 2'h2;

  // ---------------------------------------------------------------------
  // Widths, pins and timer slots
  // ---------------------------------------------------------------------
  localparam int ADDR_W = 14;
  localparam int AP_BIT = 10;
  localparam int BANKS = 8;
  localparam int LAT_W = 6;
  // Pin codes are {act_n, ras_n, cas_n, we_n}.
  localparam logic [3:0] PIN_ACT = 4'h7;
  localparam logic [3:0] PIN_MRS = 4'h8;
  localparam logic [3:0] PIN_REF = 4'h9;
  localparam logic [3:0] PIN_PRE = 4'hA;
  localparam logic [3:0] PIN_WR = 4'hC;
  localparam logic [3:0] PIN_RD = 4'hD;
  localparam logic [3:0] PIN_IDLE = 4'hF;
  localparam int TI_MRD = 0;
  localparam int TI_MOD = 1;
  localparam int TI_MPR = 2;
  localparam int TI_WTRS = 3;
  localparam int TI_WTRL = 4;
  localparam int TI_PRE = 5;
  localparam int TI_DAL = TI_PRE + BANKS;
  localparam int N_TMR = TI_DAL + BANKS;

  typedef enum logic [3:0] {
    SCTG_NOP = 4'h0,
    SCTG_ACT = 4'h1,
    SCTG_RD = 4'h2,
    SCTG_WR = 4'h3,
    SCTG_WRA = 4'h4,
    SCTG_PRE = 4'h5,
    SCTG_MRS = 4'h6,
    SCTG_MPR_RD = 4'h7,
    SCTG_MPR_WR = 4'h8,
    SCTG_REF = 4'h9
  } sctg_cmd_t;

  typedef enum logic [0:0] {
    SCTG_IDLE = 1'b0,
    SCTG_LEAD = 1'b1
  } sctg_state_t;

endpackage

// ---- logic/sctg_tmr_if.sv ----
// Interface between the guard and one spacing timer.
`timescale 1ns/1ns
interface sctg_tmr_if;
  logic load;
  logic [sctg_pkg::TW-1:0] val;
  logic busy;
  modport tmr (input load, input val, output busy);
  modport ctl (output load, output val, input busy);
endinterface

// ---- logic/sctg_timer.sv ----
// Down-counting spacing timer that never shortens a running wait.
`timescale 1ns/1ns
module sctg_timer (
  input wire logic clk_i,
  input wire logic rst_n_i,
  sctg_tmr_if.tmr t
);
  import sctg_pkg::*;

  typedef struct packed {
    logic [TW-1:0] cnt;
  } sctg_tmr_st_t;

  sctg_tmr_st_t st_r;
  sctg_tmr_st_t st_nxt;

  // A later load only wins when it asks for a longer wait.
  always_comb begin
    st_nxt = st_r;
    if (st_r.cnt != T_ZERO) begin
      st_nxt.cnt = st_r.cnt - T_ONE;
    end
    if (t.load && (t.val > st_nxt.cnt)) begin
      st_nxt.cnt = t.val;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      st_r <= '{cnt: T_ZERO};
    end else begin
      st_r <= st_nxt;
    end
  end

  assign t.busy = (st_r.cnt != T_ZERO);
endmodule

// ---- tb/sctg_guard_monitor.sv ----
// Checker of command spacing and pin timing at the guard's ports.
`timescale 1ns/1ns
module sctg_guard_monitor (
  input wire logic CLK_I,
  input wire logic RST_N_I,
  input wire logic CMD_VALID_I,
  input wire sctg_pkg::sctg_cmd_t CMD_CODE_I,
  input wire logic CMD_BG_I,
  input wire logic [1:0] CMD_BA_I,
  input wire logic CMD_READY_O,
  input wire logic CRC_EN_I,
  input wire logic DM_EN_I,
  input wire logic CAL_EN_I,
  input wire logic FAST_GRADE_I,
  input wire logic LONG_PREAMBLE_I,
  input wire logic [sctg_pkg::LAT_W-1:0] ADDITIVE_LATENCY_I,
  input wire logic [sctg_pkg::LAT_W-1:0] PARITY_LATENCY_I,
  input wire logic [sctg_pkg::LAT_W-1:0] WR_DATA_LAT_I,
  input wire logic DDR_CS_N_O,
  input wire logic DDR_ACT_N_O,
  input wire logic DDR_RAS_N_O,
  input wire logic DDR_CAS_N_O,
  input wire logic DDR_WE_N_O,
  input wire logic [1:0] RD_PREAMBLE_CYC_O,
  input wire logic RD_ISSUED_O
);
  import sctg_pkg::*;
  // Spacings are judged take to take; in latency mode the bound after an MRS
  // is 24 plus tcal for every next command, MRS included.
  logic take;
  logic [3:0] pins;
  logic [3:0] pc;
  logic [7:0] since_r;
  logic [7:0] wsince_r;
  logic [7:0] wl;
  logic [7:0] xt;
  logic [7:0] tcal;
  logic [2:0] wbk_r;
  logic wra_r;
  sctg_cmd_t last_r;
  assign take = CMD_VALID_I && CMD_READY_O;
  assign pins = {DDR_ACT_N_O, DDR_RAS_N_O, DDR_CAS_N_O, DDR_WE_N_O};
  assign wl = 8'(WR_DATA_LAT_I);
  assign xt = (CRC_EN_I && DM_EN_I) ? 8'h05 : 8'h00;
  assign tcal = FAST_GRADE_I ? 8'h05 : 8'h03;
  always_comb begin
    case (CMD_CODE_I)
      SCTG_ACT: pc = PIN_ACT;
      SCTG_MRS: pc = PIN_MRS;
      SCTG_REF: pc = PIN_REF;
      SCTG_PRE: pc = PIN_PRE;
      SCTG_WR: pc = PIN_WR;
      SCTG_RD: pc = PIN_RD;
      default: pc = PIN_IDLE;
    endcase
  end
  always_ff @(posedge CLK_I) begin
    if (!RST_N_I) begin
      since_r <= 8'hFF;
      wsince_r <= 8'hFF;
      last_r <= SCTG_NOP;
      wbk_r <= 3'h0;
      wra_r <= 1'b0;
    end else begin
      since_r <= take ? 8'h01 : since_r + 8'(since_r != 8'hFF);
      last_r <= take ? CMD_CODE_I : last_r;
      if (take && (CMD_CODE_I == SCTG_WR || CMD_CODE_I == SCTG_WRA)) begin
        wsince_r <= 8'h01;
        wbk_r <= {CMD_BG_I, CMD_BA_I};
        wra_r <= CMD_CODE_I == SCTG_WRA;
      end else begin
        wsince_r <= wsince_r + 8'(wsince_r != 8'hFF);
      end
    end
  end
  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (!RST_N_I);
  sequence lead_s; !DDR_CS_N_O && pins == PIN_IDLE; endsequence
  sequence wait_s; DDR_CS_N_O && pins == PIN_IDLE; endsequence
  sequence cmd_s; DDR_CS_N_O && pins != PIN_IDLE; endsequence
  mrs_gap_a:
  assert property (take && last_r == SCTG_MRS && CMD_CODE_I == SCTG_MRS
    && !CAL_EN_I |-> since_r >= 8'h08) else $error("MRS spacing short");
  mod_wait_a:
  assert property (take && last_r == SCTG_MRS && (CAL_EN_I ||
    CMD_CODE_I != SCTG_MRS) |-> since_r >= (CAL_EN_I ? 8'h18 + tcal :
    8'h18)) else $error("update delay short");
  mpr_wr_a:
  assert property (take && last_r == SCTG_MPR_WR |-> since_r >= 8'h18 +
    8'(ADDITIVE_LATENCY_I) + 8'(PARITY_LATENCY_I))
    else $error("readout write recovery short");
  rd_same_a:
  assert property (take && CMD_CODE_I == SCTG_RD && CMD_BG_I == wbk_r[2]
    |-> wsince_r >= wl + xt + 8'h04) else $error("same group turn short");
  rd_other_a:
  assert property (take && CMD_CODE_I == SCTG_RD && CMD_BG_I != wbk_r[2]
    |-> wsince_r >= wl + xt + 8'h02) else $error("other group turn short");
  pre_bank_a:
  assert property (take && CMD_CODE_I == SCTG_PRE && {CMD_BG_I, CMD_BA_I}
    == wbk_r |-> wsince_r >= wl + xt + 8'h01) else $error("recovery short");
  act_dal_a:
  assert property (take && CMD_CODE_I == SCTG_ACT && wra_r && {CMD_BG_I,
    CMD_BA_I} == wbk_r |-> wsince_r >= wl + xt + 8'h02)
    else $error("auto precharge recovery short");
  cal_slow_a:
  assert property (take && CAL_EN_I && !FAST_GRADE_I && pc != PIN_IDLE
    |=> lead_s ##1 wait_s [*2] ##1 cmd_s) else $error("slow lead wrong");
  cal_fast_a:
  assert property (take && CAL_EN_I && FAST_GRADE_I && pc != PIN_IDLE
    |=> lead_s ##1 wait_s [*4] ##1 cmd_s) else $error("fast lead wrong");
  issue_now_a:
  assert property (take && !CAL_EN_I && pc != PIN_IDLE |=> !DDR_CS_N_O
    && pins == $past(pc)) else $error("command not issued next cycle");
  preamble_a:
  assert property (RD_ISSUED_O && $stable(LONG_PREAMBLE_I) |->
    RD_PREAMBLE_CYC_O == (LONG_PREAMBLE_I ? PRE_LONG : PRE_SHORT))
    else $error("preamble window wrong");
endmodule

bind sctg_guard sctg_guard_monitor u_mon (
  .CLK_I(CLK_I), .RST_N_I(RST_N_I), .CMD_VALID_I(CMD_VALID_I),
  .CMD_CODE_I(CMD_CODE_I), .CMD_BG_I(CMD_BG_I), .CMD_BA_I(CMD_BA_I),
  .CMD_READY_O(CMD_READY_O), .CRC_EN_I(CRC_EN_I), .DM_EN_I(DM_EN_I),
  .CAL_EN_I(CAL_EN_I), .FAST_GRADE_I(FAST_GRADE_I),
  .LONG_PREAMBLE_I(LONG_PREAMBLE_I),
  .ADDITIVE_LATENCY_I(ADDITIVE_LATENCY_I),
  .PARITY_LATENCY_I(PARITY_LATENCY_I), .WR_DATA_LAT_I(WR_DATA_LAT_I),
  .DDR_CS_N_O(DDR_CS_N_O), .DDR_ACT_N_O(DDR_ACT_N_O),
  .DDR_RAS_N_O(DDR_RAS_N_O), .DDR_CAS_N_O(DDR_CAS_N_O),
  .DDR_WE_N_O(DDR_WE_N_O), .RD_PREAMBLE_CYC_O(RD_PREAMBLE_CYC_O),
  .RD_ISSUED_O(RD_ISSUED_O)
);

// ---- tb/sctg_dram_model.sv ----
// Device model that counts mode register spacing faults on the pins.
`timescale 1ns/1ns
module sctg_dram_model (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic [3:0] pins_i,
  input wire logic long_i,
  output logic [1:0] pre_o,
  output logic [7:0] errs_o
);
  import sctg_pkg::*;
  logic [7:0] since_r;
  logic mrs_r;
  logic [7:0] need;
  // Only the plain bounds are held here, so latency mode is judged loosely.
  assign need = (pins_i == PIN_MRS) ? 8'h08 : 8'h18;
  assign pre_o = long_i ? PRE_LONG : PRE_SHORT;
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      since_r <= 8'hFF;
      mrs_r <= 1'b0;
      errs_o <= 8'h00;
    end else if (pins_i != PIN_IDLE) begin
      since_r <= 8'h01;
      mrs_r <= pins_i == PIN_MRS;
      if (mrs_r && since_r < need) begin
        errs_o <= errs_o + 8'h01;
      end
    end else begin
      since_r <= since_r + 8'(since_r != 8'hFF);
    end
  end
endmodule

// ---- tb/tb_sdram_cmd_timing_guard.sv ----
// Bench driving the guard through spacing, latency and preamble cases.
`timescale 1ns/1ns
module tb_sdram_cmd_timing_guard;
  import sctg_pkg::*;
  logic ck, rn, v, g, crc, dm, cal, fg, lp;
  logic rdy, csn, actn, rasn, casn, wen, dbg, rdi;
  logic [1:0] b, dba, pre, mpre;
  logic [ADDR_W-1:0] ad, dad;
  logic [LAT_W-1:0] add_lat, par_lat, wl;
  logic [7:0] merr;
  sctg_cmd_t cd;
  int mismatches = 0;
  int total_checks = 0;
  int cyc = 0;
  int st[$];
  int cq[$];

  sctg_guard DUT (
    .CLK_I(ck), .RST_N_I(rn), .CMD_VALID_I(v), .CMD_CODE_I(cd),
    .CMD_BG_I(g), .CMD_BA_I(b), .CMD_ADDR_I(ad), .CMD_READY_O(rdy),
    .CRC_EN_I(crc), .DM_EN_I(dm), .CAL_EN_I(cal), .FAST_GRADE_I(fg),
    .LONG_PREAMBLE_I(lp), .ADDITIVE_LATENCY_I(add_lat),
    .PARITY_LATENCY_I(par_lat), .WR_DATA_LAT_I(wl), .DDR_CS_N_O(csn),
    .DDR_ACT_N_O(actn), .DDR_RAS_N_O(rasn), .DDR_CAS_N_O(casn),
    .DDR_WE_N_O(wen), .DDR_BG_O(dbg), .DDR_BA_O(dba), .DDR_ADDR_O(dad),
    .RD_PREAMBLE_CYC_O(pre), .RD_ISSUED_O(rdi)
  );
  sctg_dram_model u_dram (
    .clk_i(ck), .rst_n_i(rn), .pins_i({actn, rasn, casn, wen}),
    .long_i(lp), .pre_o(mpre), .errs_o(merr)
  );

  initial begin
    ck = 1'b0;
    forever #50 ck = ~ck;
  end
  // Cycle stamps of command pins and of chip select give the spacings.
  // They are taken on the falling edge, where the outputs have settled.
  always @(negedge ck) begin
    cyc <= cyc + 1;
    if ({actn, rasn, casn, wen} !== PIN_IDLE && rn) st.push_back(cyc);
    if (csn === 1'b0 && rn) cq.push_back(cyc);
  end

  task automatic check(input string nm, input logic [7:0] seen,
      input logic [7:0] exp);
    total_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("[FAIL] %s expected %0h seen %0h", nm, exp, seen);
    end
  endtask

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // Entered at a falling edge; returns at the falling edge after the take.
  task automatic send(input sctg_cmd_t c, input logic [2:0] bk);
    int n;
    cd = c;
    {g, b} = bk;
    ad = (c == SCTG_WRA) ? 14'h0400 : 14'h0000;
    v = 1'b1;
    n = 0;
    #1;
    while (rdy !== 1'b1 && n < 300) begin
      @(negedge ck);
      #1;
      n++;
    end
    if (n == 300) mismatches++;
    @(negedge ck);
  endtask

  // The idle tail drains every running spacing before the next case.
  task automatic gap(input string nm, input sctg_cmd_t c1,
      input sctg_cmd_t c2, input logic [2:0] bk, input logic [7:0] exp);
    st.delete();
    send(c1, 3'h0);
    send(c2, bk);
    v = 1'b0;
    repeat (60) @(negedge ck);
    check(nm, 8'(st[1] - st[0]), exp);
  endtask

  task automatic t_mode();
    gap("mrs_mrs", SCTG_MRS, SCTG_MRS, 3'h0, 8'h08);
    gap("mrs_act", SCTG_MRS, SCTG_ACT, 3'h0, 8'h18);
    gap("mrs_ref", SCTG_MRS, SCTG_REF, 3'h0, 8'h18);
  endtask

  task automatic t_mpr();
    add_lat = 6'h02;
    par_lat = 6'h01;
    gap("mpr_wr", SCTG_MPR_WR, SCTG_ACT, 3'h0, 8'h1B);
    gap("mpr_rd", SCTG_MPR_RD, SCTG_ACT, 3'h0, 8'h01);
  endtask

  task automatic t_write();
    crc = 1'b1;
    dm = 1'b1;
    gap("wr_rd_s", SCTG_WR, SCTG_RD, 3'h1, 8'h0F);
    gap("wr_rd_o", SCTG_WR, SCTG_RD, 3'h4, 8'h0D);
    gap("wr_pre", SCTG_WR, SCTG_PRE, 3'h0, 8'h0C);
    gap("wra_act", SCTG_WRA, SCTG_ACT, 3'h0, 8'h0D);
    // Address and bank stand on the pins until the next command.
    send(SCTG_WRA, 3'h6);
    v = 1'b0;
    check("ap_bit", {7'h00, dad[AP_BIT]}, 8'h01);
    check("wr_bank", {5'h00, dbg, dba}, 8'h06);
    repeat (30) @(negedge ck);
    dm = 1'b0;
    gap("wr_rd_c", SCTG_WR, SCTG_RD, 3'h1, 8'h0A);
    crc = 1'b0;
  endtask

  task automatic t_cal();
    cal = 1'b1;
    for (int i = 0; i < 2; i++) begin
      fg = 1'(i);
      st.delete();
      cq.delete();
      send(SCTG_MRS, 3'h0);
      send(SCTG_MRS, 3'h0);
      send(SCTG_ACT, 3'h0);
      v = 1'b0;
      repeat (60) @(negedge ck);
      check("lead", 8'(st[0] - cq[0]), i ? 8'h05 : 8'h03);
      check("c_mrs", 8'(st[1] - st[0] >= 27 + 2 * i), 8'h01);
      check("c_oth", 8'(st[2] - st[1] >= 27 + 2 * i), 8'h01);
    end
    cal = 1'b0;
  endtask

  task automatic t_pre();
    for (int i = 0; i < 2; i++) begin
      lp = 1'(i);
      repeat (2) @(negedge ck);
      send(SCTG_RD, 3'h0);
      v = 1'b0;
      check("rd_pulse", {7'h00, rdi}, 8'h01);
      check("preamble", {6'h00, pre}, i ? 8'h02 : 8'h01);
      check("pre_agree", {6'h00, pre}, {6'h00, mpre});
      repeat (10) @(negedge ck);
    end
  endtask

  initial begin
    {v, g, crc, dm, cal, fg, lp, rn} = 8'h00;
    cd = SCTG_NOP;
    b = 2'h0;
    ad = 14'h0000;
    {add_lat, par_lat} = 12'h000;
    wl = 6'h06;
    repeat (20) @(negedge ck);
    rn = 1'b1;
    @(negedge ck);
    t_mode();
    t_mpr();
    t_write();
    t_cal();
    t_pre();
    check("dev_err", merr, 8'h00);
    tally_and_finish();
  end

  // The cases need some eleven hundred cycles; ten thousand means a hang.
  initial begin
    #1000000;
    mismatches++;
    tally_and_finish();
  end
endmodule
